//--- rtl/irq_prio_params.svh
/*
  Offsets, field positions, write masks and reset values of the interrupt
  priority and vector registers. Assumes inclusion by bare name from rtl/.
*/
`ifndef IRQ_PRIO_PARAMS_SVH
`define IRQ_PRIO_PARAMS_SVH

// printed offsets are register indices; byte address is four times the index
`define IDX_PRIORITY_REG_SECOND   28'hFFFFE60
`define IDX_VECTOR_REG_FIRST      32'hFFFFFE62
`define IDX_VECTOR_REG_SECOND     32'hFFFFFE64
`define IDX_PRIORITY_REG_FIRST    32'hFFFFFEE2

// only the low index bits are decoded; the high bits alias
`define IDX_DECODE_MSB            9
`define ADDR_DECODE_MSB           11
`define ADDR_DECODE_LSB           2

// field positions inside the 16-bit registers
`define DIVIDER_PRIO_MSB          15
`define DIVIDER_PRIO_LSB          12
`define DMA_PRIO_MSB              11
`define DMA_PRIO_LSB              8
`define WATCHDOG_PRIO_MSB         7
`define WATCHDOG_PRIO_LSB         4
`define SERIAL_PRIO_MSB           15
`define SERIAL_PRIO_LSB           12
`define FREERUN_PRIO_MSB          11
`define FREERUN_PRIO_LSB          8
`define VEC_HIGH_MSB              14
`define VEC_HIGH_LSB              8
`define VEC_LOW_MSB               6
`define VEC_LOW_LSB               0

// writable bits; the rest read zero
`define WMASK_PRIORITY_FIRST      16'hFFF0
`define WMASK_PRIORITY_SECOND     16'hFF00
`define WMASK_VECTOR              16'h7F7F

`define RESET_REG16               16'h0000

`define AXI_RESP_OKAY             2'h0
`define AXI_RESP_SLVERR           2'h2

`endif

//--- rtl/irq_prio_pkg.sv
/*
  Types shared by the interrupt priority and vector register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irq_prio_pkg;

  typedef struct packed {
    logic [3:0] divider_prio_field;
    logic [3:0] dma_prio_field;
    logic [3:0] watchdog_prio_field;
    logic [3:0] serial_prio_field;
    logic [3:0] freerun_timer_prio_field;
  } prio_set_type;

  typedef struct packed {
    logic [6:0] rx_error_vector_field;
    logic [6:0] rx_full_vector_field;
    logic [6:0] tx_empty_vector_field;
    logic [6:0] tx_end_vector_field;
  } vector_set_type;

  typedef enum logic [3:0] {
    REG_PRIORITY_FIRST  = 4'h1,
    REG_PRIORITY_SECOND = 4'h2,
    REG_VECTOR_FIRST    = 4'h4,
    REG_VECTOR_SECOND   = 4'h8
  } reg_sel_type;

endpackage

//--- rtl/masked_reg16.sv
/*
  One 16-bit register with byte-lane writes and a fixed mask of writable bits.
  Assumes write enable and strobes arrive on core_clk, one cycle long.
*/
`timescale 1ns/1ps
`include "irq_prio_params.svh"

module masked_reg16 #(
  parameter logic [15:0] WMASK = 16'hFFFF,
  parameter logic [15:0] RESET = 16'h0000
) (
  input  wire logic        core_clk, // system clock
  input  wire logic        srst,     // sync reset, active high
  input  wire logic        wr_en,    // write this register
  input  wire logic [1:0]  wr_strb,  // byte lanes to write
  input  wire logic [15:0] wr_data,  // write data
  output logic      [15:0] q         // register contents
);

  logic [15:0] lane_mask;

  always_comb begin
    lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  end

  // unwritten lanes keep their value; masked bits stay zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= RESET & WMASK; // [RULE10]
    end else if (wr_en) begin
      q <= ((q & ~lane_mask) | (wr_data & lane_mask)) & WMASK; // [RULE10] [RULE11]
    end
  end

endmodule

//--- rtl/irq_prio_vector_regs.sv
/*
  Priority-level and vector-number registers of the on-chip interrupt
  controller, reached over AXI4-Lite. Assumes the arbitration and vector
  logic of the controller sits outside and reads the field outputs.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
//
// Function
// RULE1: first priority register bits 15..12 hold the division unit level.
// RULE2: first priority register bits 11..8 hold the dma controller level.
// RULE3: first priority register bits 7..4 hold watchdog and bus state controller level.
// RULE4: second priority register bits 15..12 hold the serial interface level.
// RULE5: second priority register bits 11..8 hold the free-running timer level.
// RULE6: first vector register bits 14..8 hold the receive-error vector.
// RULE7: first vector register bits 6..0 hold the receive-full vector.
// RULE8: second vector register bits 14..8 hold the transmit-empty vector.
// RULE9: second vector register bits 6..0 hold the transmit-end vector.
// RULE10: all fields reset to zero; unused bits read zero and ignore writes.
// RULE11: byte and halfword writes and reads allowed; byte writes touch one byte.
`timescale 1ns/1ps
`include "irq_prio_params.svh"

module irq_prio_vector_regs
  import irq_prio_pkg::*;
(
  input  wire logic        core_clk,      // system clock, 50 MHz
  input  wire logic        srst,          // sync reset, active high
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic [2:0]  s_axi_awprot,  // write protection, unused
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic [2:0]  s_axi_arprot,  // read protection, unused
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output prio_set_type     prio_levels,   // priority levels per source
  output vector_set_type   serial_vectors // serial interface vector numbers
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // the index is cut to the decoded bits on purpose; upper bits alias
  localparam logic [9:0] SEL_PRIO_FIRST  = 10'(`IDX_PRIORITY_REG_FIRST);
  localparam logic [9:0] SEL_PRIO_SECOND = 10'(`IDX_PRIORITY_REG_SECOND);
  localparam logic [9:0] SEL_VEC_FIRST   = 10'(`IDX_VECTOR_REG_FIRST);
  localparam logic [9:0] SEL_VEC_SECOND  = 10'(`IDX_VECTOR_REG_SECOND);

  function automatic reg_sel_type decode(input logic [31:0] addr);
    logic [9:0] idx;
    idx = addr[`ADDR_DECODE_MSB:`ADDR_DECODE_LSB];
    case (idx)
      SEL_PRIO_FIRST:  decode = REG_PRIORITY_FIRST;
      SEL_PRIO_SECOND: decode = REG_PRIORITY_SECOND;
      SEL_VEC_FIRST:   decode = REG_VECTOR_FIRST;
      SEL_VEC_SECOND:  decode = REG_VECTOR_SECOND;
      default:         decode = reg_sel_type'(4'h0);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  logic [31:0] aw_addr;
  logic        aw_held;
  logic [15:0] w_data;
  logic [1:0]  w_strb;
  logic        w_held;
  logic        do_write;
  reg_sel_type wr_sel;

  always_comb begin
    do_write = aw_held && w_held && !s_axi_bvalid;
    wr_sel   = decode(aw_addr);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held       <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held       <= 1'b0;
    end else begin
      // one write in flight: no new address until the response is taken
      s_axi_awready <= !aw_held && !(s_axi_bvalid && !s_axi_bready);
    end
  end

  // only the low halfword lanes carry register bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      w_held       <= 1'b0;
      w_data       <= 16'h0000;
      w_strb       <= 2'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata[15:0];
      w_strb       <= s_axi_wstrb[1:0]; // [RULE11]
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held       <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !(s_axi_bvalid && !s_axi_bready);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == reg_sel_type'(4'h0)) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] prio_first;
  logic [15:0] prio_second;
  logic [15:0] vec_first;
  logic [15:0] vec_second;

  masked_reg16 #(
    .WMASK (`WMASK_PRIORITY_FIRST),
    .RESET (`RESET_REG16)
  ) u_prio_first (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (do_write && wr_sel == REG_PRIORITY_FIRST),
    .wr_strb  (w_strb),
    .wr_data  (w_data),
    .q        (prio_first)
  );

  masked_reg16 #(
    .WMASK (`WMASK_PRIORITY_SECOND),
    .RESET (`RESET_REG16)
  ) u_prio_second (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (do_write && wr_sel == REG_PRIORITY_SECOND),
    .wr_strb  (w_strb),
    .wr_data  (w_data),
    .q        (prio_second)
  );

  masked_reg16 #(
    .WMASK (`WMASK_VECTOR),
    .RESET (`RESET_REG16)
  ) u_vec_first (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (do_write && wr_sel == REG_VECTOR_FIRST),
    .wr_strb  (w_strb),
    .wr_data  (w_data),
    .q        (vec_first)
  );

  masked_reg16 #(
    .WMASK (`WMASK_VECTOR),
    .RESET (`RESET_REG16)
  ) u_vec_second (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (do_write && wr_sel == REG_VECTOR_SECOND),
    .wr_strb  (w_strb),
    .wr_data  (w_data),
    .q        (vec_second)
  );

  ////////////////////////////////////////////////////////////////////////////
  // field outputs, wired straight from the register flops

  always_comb begin
    prio_levels.divider_prio_field       = prio_first[`DIVIDER_PRIO_MSB:`DIVIDER_PRIO_LSB];    // [RULE1]
    prio_levels.dma_prio_field           = prio_first[`DMA_PRIO_MSB:`DMA_PRIO_LSB];            // [RULE2]
    // one level serves both watchdog and bus state controller
    prio_levels.watchdog_prio_field      = prio_first[`WATCHDOG_PRIO_MSB:`WATCHDOG_PRIO_LSB];  // [RULE3]
    prio_levels.serial_prio_field        = prio_second[`SERIAL_PRIO_MSB:`SERIAL_PRIO_LSB];     // [RULE4]
    prio_levels.freerun_timer_prio_field = prio_second[`FREERUN_PRIO_MSB:`FREERUN_PRIO_LSB];   // [RULE5]
    serial_vectors.rx_error_vector_field = vec_first[`VEC_HIGH_MSB:`VEC_HIGH_LSB];             // [RULE6]
    serial_vectors.rx_full_vector_field  = vec_first[`VEC_LOW_MSB:`VEC_LOW_LSB];               // [RULE7]
    serial_vectors.tx_empty_vector_field = vec_second[`VEC_HIGH_MSB:`VEC_HIGH_LSB];            // [RULE8]
    serial_vectors.tx_end_vector_field   = vec_second[`VEC_LOW_MSB:`VEC_LOW_LSB];              // [RULE9]
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read in flight, answer one cycle after the address

  reg_sel_type rd_sel;
  logic [15:0] rd_word;

  always_comb begin
    rd_sel = decode(s_axi_araddr);
    case (rd_sel)
      REG_PRIORITY_FIRST:  rd_word = prio_first;
      REG_PRIORITY_SECOND: rd_word = prio_second;
      REG_VECTOR_FIRST:    rd_word = vec_first;
      REG_VECTOR_SECOND:   rd_word = vec_second;
      default:             rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // whole word returned; software picks the byte or halfword it wants
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_word}; // [RULE10] [RULE11]
      s_axi_rresp  <= (rd_sel == reg_sel_type'(4'h0)) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- test/irq_prio_chk.sv
/*
  Assertions on the priority/vector register block.
  Assumes binding to irq_prio_vector_regs; sees its ports only.
*/
`timescale 1ns/1ps
`include "irq_prio_params.svh"
module irq_prio_chk
  import irq_prio_pkg::*;
(
  input wire logic           core_clk,       // clock
  input wire logic           srst,           // sync reset
  input wire logic           s_axi_awvalid,  // aw valid
  input wire logic           s_axi_awready,  // aw ready
  input wire logic           s_axi_wvalid,   // w valid
  input wire logic           s_axi_wready,   // w ready
  input wire logic [1:0]     s_axi_bresp,    // b response
  input wire logic           s_axi_bvalid,   // b valid
  input wire logic           s_axi_bready,   // b ready
  input wire logic [31:0]    s_axi_araddr,   // read address
  input wire logic           s_axi_arvalid,  // ar valid
  input wire logic           s_axi_arready,  // ar ready
  input wire logic [31:0]    s_axi_rdata,    // read data
  input wire logic [1:0]     s_axi_rresp,    // r response
  input wire logic           s_axi_rvalid,   // r valid
  input wire logic           s_axi_rready,   // r ready
  input wire prio_set_type   prio_levels,    // levels
  input wire vector_set_type serial_vectors  // vectors
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [15:0] exp_w;
  logic [15:0] exp_q;
  logic [1:0]  resp_q;
  logic        hit;
  ////////////////////////////////////////////////////////////////
  // expected read word built from the field outputs at the take
  always_comb begin
    hit = 1'b1;
    case (s_axi_araddr[11:2])
      10'h2E2: exp_w = {prio_levels[19:8], 4'h0};
      10'h260: exp_w = {prio_levels[7:0], 8'h00};
      10'h262: exp_w = {1'b0, serial_vectors[27:21], 1'b0, serial_vectors[20:14]};
      10'h264: exp_w = {1'b0, serial_vectors[13:7], 1'b0, serial_vectors[6:0]};
      default: begin
        hit = 1'b0;
        exp_w = 16'h0000;
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      exp_q <= 16'h0000;
      resp_q <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      exp_q <= exp_w;
      resp_q <= hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end
  end
  ////////////////////////////////////////////////////////////////
  read_word_a:
    assert property ($rose(s_axi_rvalid) |-> s_axi_rdata[15:0] == exp_q && s_axi_rresp == resp_q)
      else $error("read word differs from fields");
  rdata_upper_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
  reset_clear_a:
    assert property ($past(srst) |-> prio_levels == '0 && serial_vectors == '0 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("state not cleared by reset");
  fields_stable_a:
    assert property (!$past(srst) && !$rose(s_axi_bvalid) |-> $stable(prio_levels) && $stable(serial_vectors))
      else $error("fields changed without a write");
  bad_write_a:
    assert property ($rose(s_axi_bvalid) && s_axi_bresp == `AXI_RESP_SLVERR |-> $stable(prio_levels)
      && $stable(serial_vectors)) else $error("refused write changed fields");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("read response late");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  busy_ready_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && !$rose(s_axi_awready))
      else $error("ready while response pending");
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == `AXI_RESP_OKAY);
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == `AXI_RESP_SLVERR);
  cover property ($rose(s_axi_rvalid) && resp_q == `AXI_RESP_OKAY);
endmodule
bind irq_prio_vector_regs irq_prio_chk u_chk (
  .core_clk       (core_clk),
  .srst           (srst),
  .s_axi_awvalid  (s_axi_awvalid),
  .s_axi_awready  (s_axi_awready),
  .s_axi_wvalid   (s_axi_wvalid),
  .s_axi_wready   (s_axi_wready),
  .s_axi_bresp    (s_axi_bresp),
  .s_axi_bvalid   (s_axi_bvalid),
  .s_axi_bready   (s_axi_bready),
  .s_axi_araddr   (s_axi_araddr),
  .s_axi_arvalid  (s_axi_arvalid),
  .s_axi_arready  (s_axi_arready),
  .s_axi_rdata    (s_axi_rdata),
  .s_axi_rresp    (s_axi_rresp),
  .s_axi_rvalid   (s_axi_rvalid),
  .s_axi_rready   (s_axi_rready),
  .prio_levels    (prio_levels),
  .serial_vectors (serial_vectors)
);

//--- test/irq_sink_model.sv
/*
  Consumer of the levels and vectors: per-source lookup as the arbiter sees it.
  Assumes the field outputs of the register block.
*/
`timescale 1ns/1ps
module irq_sink_model
  import irq_prio_pkg::*;
(
  input  wire prio_set_type   prio_levels,    // levels from block
  input  wire vector_set_type serial_vectors, // vectors from block
  output logic [3:0]          src_level [6],  // divider dma watchdog bus_ctl serial timer
  output logic [6:0]          ser_vector [4]  // rx error, rx full, tx empty, tx end
);
  always_comb begin
    src_level[0] = prio_levels.divider_prio_field;
    src_level[1] = prio_levels.dma_prio_field;
    src_level[2] = prio_levels.watchdog_prio_field;
    // bus controller has no field of its own
    src_level[3] = prio_levels.watchdog_prio_field;
    src_level[4] = prio_levels.serial_prio_field;
    src_level[5] = prio_levels.freerun_timer_prio_field;
    ser_vector[0] = serial_vectors.rx_error_vector_field;
    ser_vector[1] = serial_vectors.rx_full_vector_field;
    ser_vector[2] = serial_vectors.tx_empty_vector_field;
    ser_vector[3] = serial_vectors.tx_end_vector_field;
  end
endmodule

//--- test/testbench.sv
/*
  Self-checking bench: AXI4-Lite master, register model, sink model.
  Assumes the register block and its checker bind.
*/
`timescale 1ns/1ps
`include "irq_prio_params.svh"
module testbench
  import irq_prio_pkg::*;
;
  logic           core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [31:0]    awaddr, wdata, araddr, rdata;
  logic [3:0]     wstrb;
  logic [1:0]     bresp, rresp;
  prio_set_type   prio;
  vector_set_type vecs;
  logic [3:0]     lvl [6];
  logic [6:0]     svec [4];
  logic [15:0]    mdl [4];
  logic [15:0]    wm [4];
  logic [31:0]    adr [5];
  int             n_errors, checks, k;
  irq_prio_vector_regs u_dut (.core_clk(core_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .prio_levels(prio), .serial_vectors(vecs));
  irq_sink_model u_sink (.prio_levels(prio), .serial_vectors(vecs), .src_level(lvl), .ser_vector(svec));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // index 4 is an unmapped word
  task automatic wr(int i, logic [31:0] d, logic [3:0] s, int dly = 0);
    logic a, w, b;
    int n;
    @(posedge core_clk);
    a = 1'b1;
    w = 1'b1;
    b = 1'b1;
    awaddr <= adr[i];
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (dly == 0);
    for (n = 0; n < 40 && b; n++) begin
      @(posedge core_clk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid && bready) begin
        b = 1'b0;
        bready <= 1'b0;
        cmp("bresp", i < 4 ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR, bresp);
      end else if (n + 1 >= dly) begin
        bready <= 1'b1;
      end
    end
    if (b) begin
      n_errors++;
      stop_test();
    end
    if (i < 4)
      for (n = 0; n < 2; n++)
        if (s[n]) mdl[i][8*n+:8] = d[8*n+:8] & wm[i][8*n+:8];
  endtask
  task automatic rd(int i, int dly = 0);
    logic r;
    int n;
    @(posedge core_clk);
    r = 1'b1;
    araddr <= adr[i];
    arvalid <= 1'b1;
    rready <= (dly == 0);
    for (n = 0; n < 40 && r; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        r = 1'b0;
        rready <= 1'b0;
        cmp("rdata", i < 4 ? {16'h0000, mdl[i]} : 32'h0, rdata);
        cmp("rresp", i < 4 ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR, rresp);
      end else if (n + 1 >= dly) begin
        rready <= 1'b1;
      end
    end
    if (r) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic outs();
    cmp("prio", {mdl[0][15:4], mdl[1][15:8]}, prio);
    cmp("vecs", {mdl[2][14:8], mdl[2][6:0], mdl[3][14:8], mdl[3][6:0]}, vecs);
    cmp("bus_ctl_lvl", mdl[0][7:4], lvl[3]);
    cmp("timer_lvl", mdl[1][11:8], lvl[5]);
    cmp("tx_end_vec", mdl[3][6:0], svec[3]);
    cmp("src_lvl", {mdl[0][15:4], mdl[0][7:4], mdl[1][15:8]}, {lvl[0], lvl[1], lvl[2], lvl[3], lvl[4], lvl[5]});
    cmp("ser_vec", {mdl[2][14:8], mdl[2][6:0], mdl[3][14:8], mdl[3][6:0]}, {svec[0], svec[1], svec[2], svec[3]});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, wdata, araddr, wstrb} = '0;
    n_errors = 0;
    checks = 0;
    wm = '{`WMASK_PRIORITY_FIRST, `WMASK_PRIORITY_SECOND, `WMASK_VECTOR, `WMASK_VECTOR};
    adr = '{`IDX_PRIORITY_REG_FIRST << 2, 32'(`IDX_PRIORITY_REG_SECOND) << 2, `IDX_VECTOR_REG_FIRST << 2,
            `IDX_VECTOR_REG_SECOND << 2, 32'h00000004};
    mdl = '{default: 16'h0000};
    k = $urandom(19011);
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    for (k = 0; k < 4; k++) rd(k);
    outs();
    $display("test reset values done");
    for (k = 0; k < 4; k++) begin
      wr(k, 32'hFFFFFFFF, 4'hF);
      rd(k);
      outs();
    end
    $display("test all ones done");
    for (k = 0; k < 4; k++) begin
      wr(k, $urandom, 4'h1);
      rd(k);
      wr(k, $urandom, 4'hE);
      rd(k);
    end
    outs();
    $display("test byte lanes done");
    // answer held back by a late ready must stand unchanged
    wr(3, $urandom, 4'h3, 4);
    rd(3, 5);
    outs();
    $display("test held response done");
    wr(4, 32'h0000FFFF, 4'h3);
    rd(4);
    outs();
    $display("test unmapped done");
    repeat (24) begin
      k = $urandom_range(0, 3);
      wr(k, $urandom, 4'($urandom_range(0, 15)));
      rd(k);
      outs();
    end
    $display("test random done");
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    mdl = '{default: 16'h0000};
    outs();
    for (k = 0; k < 4; k++) rd(k);
    $display("test second reset done");
    stop_test();
  end
endmodule
